// [rtl/fml_pkg.sv]
// Purpose: Shared types and constants of the floating-point coprocessor link
// Assumes: 32-bit memory words, 32 single registers aliased as 16 doubles
// Notes: Rounding codes follow the usual two-bit mode field
package fml_pkg;

    // ************************************************************
    // Operations
    // ************************************************************
    typedef enum logic [3:0] {
        OP_FUSED_MUL_ACC,
        OP_FUSED_MUL_SUB,
        OP_FUSED_NEG_MUL_ACC,
        OP_FUSED_NEG_MUL_SUB,
        OP_UNFUSED_MUL_ACC,
        OP_UNFUSED_MUL_SUB,
        OP_MULTI_REG_LOAD,
        OP_SINGLE_REG_LOAD,
        OP_FP_MOVE_IMM,
        OP_FP_MOVE_REG,
        OP_FP_MOVE_TO_INT
    } fml_op_e;

    // ************************************************************
    // Constants
    // ************************************************************
    localparam logic [1:0] RM_NEAREST = 2'h0;
    localparam logic [1:0] RM_PLUS = 2'h1;
    localparam logic [1:0] RM_MINUS = 2'h2;
    localparam logic [1:0] RM_ZERO = 2'h3;
    localparam logic [1:0] SIZE_NONE = 2'h0;
    localparam logic [1:0] SIZE_32 = 2'h1;
    localparam logic [1:0] SIZE_64 = 2'h2;
    localparam logic [31:0] ADDR_STEP = 32'h4;
    localparam logic [31:0] ONE_S = 32'h3f80_0000;
    localparam logic [63:0] ONE_D = 64'h3ff0_0000_0000_0000;
    localparam logic [5:0] LIST_MAX_D = 6'h10;
    localparam logic [9:0] OFF_MAX = 10'h3fc;
    localparam logic [3:0] INT_SP = 4'hd;
    localparam logic [3:0] INT_PC = 4'hf;
    localparam int EXP_S = 8;
    localparam int MAN_S = 23;
    localparam int EXP_D = 11;
    localparam int MAN_D = 52;

    // ************************************************************
    // Request carried over the link
    // ************************************************************
    typedef struct packed {
        fml_op_e op;
        logic dbl;
        logic [4:0] dst;
        logic [4:0] srcn;
        logic [4:0] srcm;
        logic [7:0] imm;
        logic sub;
        logic decb;
        logic wback;
        logic [5:0] cnt;
        logic half;
        logic [1:0] rmode;
        logic [31:0] base;
    } fml_req_s;

endpackage : fml_pkg

// [rtl/fml_if.sv]
// Purpose: Link between the integer core and the floating-point unit
// Assumes: Both ends on sys_clk_i
// Notes: Memory words flow core to unit while mem_req is high
`timescale 1ns/1ps
interface fml_if;
    logic req_valid;
    logic req_ready;
    fml_pkg::fml_req_s req;
    logic done;
    logic wb_valid;
    logic [31:0] wb_data;
    logic mov_valid;
    logic [31:0] mov_data;
    logic mem_req;
    logic [31:0] mem_addr;
    logic mem_rvalid;
    logic [31:0] mem_rdata;

    modport core (
        output req_valid, req, mem_rvalid, mem_rdata,
        input req_ready, done, wb_valid, wb_data, mov_valid, mov_data, mem_req, mem_addr
    );
    modport fpu (
        input req_valid, req, mem_rvalid, mem_rdata,
        output req_ready, done, wb_valid, wb_data, mov_valid, mov_data, mem_req, mem_addr
    );
endinterface : fml_if

// [rtl/fml_fma.sv]
// Purpose: Combinational multiply-add with one final rounding
// Assumes: Subnormal inputs read as zero, tiny results flush to zero
// Notes: Any infinity or NaN operand gives the default NaN
`timescale 1ns/1ps
module fml_fma #(
    parameter int EW = 8,
    parameter int MW = 23
) (
    // Operands
    input wire logic [EW+MW:0] a_i,
    input wire logic [EW+MW:0] b_i,
    input wire logic [EW+MW:0] c_i,
    // Controls
    input wire logic neg_prod_i,
    input wire logic neg_add_i,
    input wire logic [1:0] rmode_i,
    // Result
    output logic [EW+MW:0] res_o
);
    localparam int F = MW + 1;
    localparam int W = 3 * F + 3;
    localparam int BIAS = 2 ** (EW - 1) - 1;
    localparam int EMAX = 2 ** EW - 1;
    localparam int T = EW + MW;

    logic [EW-1:0] ea, eb, ec;
    logic [F-1:0] ma, mb, mc;
    logic [2*F-1:0] prod;
    logic [W-1:0] xp, xc, big, sml;
    logic [W:0] sum, nrm;
    logic [F:0] rnd;
    logic sp, sc, sb, ss, sr, pz, cz, g, st, rs, inc;
    int elp, elc, elb, d, pos, er;

    assign ea = a_i[T-1:MW];
    assign eb = b_i[T-1:MW];
    assign ec = c_i[T-1:MW];
    assign ma = (ea == '0) ? '0 : {1'b1, a_i[MW-1:0]};
    assign mb = (eb == '0) ? '0 : {1'b1, b_i[MW-1:0]};
    assign mc = (ec == '0) ? '0 : {1'b1, c_i[MW-1:0]};
    // Full-width product, never rounded before the add
    assign prod = ma * mb;

    always_comb begin
        sp = a_i[T] ^ b_i[T] ^ neg_prod_i;
        sc = c_i[T] ^ neg_add_i;
        pz = (ea == '0) || (eb == '0);
        cz = (ec == '0);
        elp = int'(ea) + int'(eb) - 2 * BIAS - 2 * MW;
        elc = int'(ec) - BIAS - MW - F;
        xp = pz ? '0 : {prod, {(F + 3){1'b0}}};
        xc = cz ? '0 : {mc, {(2 * F + 3){1'b0}}};
        if (pz) elp = elc;
        if (cz) elc = elp;
        if (elp >= elc) begin
            big = xp;
            sml = xc;
            sb = sp;
            ss = sc;
            d = elp - elc;
            elb = elp;
        end else begin
            big = xc;
            sml = xp;
            sb = sc;
            ss = sp;
            d = elc - elp;
            elb = elc;
        end
        if (d > W) d = W;
        // Bits shifted out are jammed into the lsb so cancellation rounds right
        st = |(sml & ~({W{1'b1}} << d));
        sml = (sml >> d) | W'(st);
        if (sb == ss) begin
            sum = {1'b0, big} + {1'b0, sml};
            sr = sb;
        end else if (big >= sml) begin
            sum = {1'b0, big - sml};
            sr = sb;
        end else begin
            sum = {1'b0, sml - big};
            sr = ss;
        end
        pos = 0;
        for (int i = 0; i <= W; i++) begin
            if (sum[i]) pos = i;
        end
        nrm = sum << (W - pos);
        g = nrm[W-F];
        rs = |nrm[W-F-1:0];
        // Single rounding step in the selected mode
        case (rmode_i)
            fml_pkg::RM_NEAREST: inc = g & (rs | nrm[W-F+1]);
            fml_pkg::RM_PLUS: inc = ~sr & (g | rs);
            fml_pkg::RM_MINUS: inc = sr & (g | rs);
            default: inc = 1'b0;
        endcase
        rnd = {1'b0, nrm[W -: F]} + (F + 1)'(inc);
        er = elb - (F + 3) + pos + BIAS + int'(rnd[F]);
        // Overflow always saturates to infinity, even toward zero
        if ((&ea) || (&eb) || (&ec)) begin
            res_o = {1'b0, {EW{1'b1}}, 1'b1, {(MW - 1){1'b0}}};
        end else if (sum == '0) begin
            res_o = {(pz && cz) ? (sp & sc) : (rmode_i == fml_pkg::RM_MINUS), {T{1'b0}}};
        end else if (er >= EMAX) begin
            res_o = {sr, {EW{1'b1}}, {MW{1'b0}}};
        end else if (er <= 0) begin
            res_o = {sr, {T{1'b0}}};
        end else begin
            res_o = {sr, EW'(er), rnd[F] ? {MW{1'b0}} : rnd[MW-1:0]};
        end
    end

endmodule : fml_fma

// [rtl/fml_core_end.sv]
// Purpose: Integer core end: checks and issues instructions, serves memory
// Assumes: Memory answers on sys_clk_i
// Notes: Refused instructions never reach the link
`timescale 1ns/1ps
module fml_core_end (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Instruction issue
    input wire logic cmd_valid_i,
    input wire fml_pkg::fml_req_s cmd_i,
    input wire logic [1:0] cmd_size_i,
    input wire logic [9:0] cmd_off_i,
    input wire logic [3:0] cmd_rt_i,
    output logic cmd_ready_o,
    output logic illegal_o,
    output logic done_o,
    // Results
    output logic wb_valid_o,
    output logic [31:0] wb_data_o,
    output logic mov_valid_o,
    output logic [31:0] mov_data_o,
    output logic [3:0] mov_rt_o,
    // Memory load path
    output logic mem_req_o,
    output logic [31:0] mem_addr_o,
    input wire logic mem_rvalid_i,
    input wire logic [31:0] mem_rdata_i,
    // Link
    fml_if.core link
);
    typedef enum {C_IDLE, C_ISSUE, C_WAIT} fml_cst_e;
    typedef struct packed {
        fml_cst_e st;
        fml_pkg::fml_req_s rq;
        logic illegal;
        logic [3:0] rt;
    } fml_cst_s;

    fml_cst_s r, next_r;
    logic is_multi, is_single, bad;

    // ************************************************************
    // Checks
    // ************************************************************
    assign is_multi = cmd_i.op == fml_pkg::OP_MULTI_REG_LOAD;
    assign is_single = cmd_i.op == fml_pkg::OP_SINGLE_REG_LOAD;
    assign bad = (is_multi && (cmd_i.cnt == 6'h0))
        || (is_multi && cmd_i.dbl && (cmd_i.cnt > fml_pkg::LIST_MAX_D))
        || ((is_multi || is_single) && (cmd_size_i != fml_pkg::SIZE_NONE)
            && ((cmd_size_i == fml_pkg::SIZE_64) != cmd_i.dbl))
        || (is_multi && cmd_i.decb && !cmd_i.wback)
        || (is_single && ((cmd_off_i[1:0] != 2'h0)
            || (cmd_off_i > fml_pkg::OFF_MAX)))
        || ((cmd_i.op == fml_pkg::OP_FP_MOVE_TO_INT)
            && ((cmd_rt_i == fml_pkg::INT_SP) || (cmd_rt_i == fml_pkg::INT_PC)));

    // ************************************************************
    // Issue sequence
    // ************************************************************
    always_comb begin
        next_r = r;
        next_r.illegal = 1'b0;
        case (r.st)
            C_IDLE: begin
                if (cmd_valid_i) begin
                    if (bad) begin
                        next_r.illegal = 1'b1;
                    end else begin
                        next_r.rq = cmd_i;
                        if (is_single) next_r.rq.imm = cmd_off_i[9:2];
                        next_r.rt = cmd_rt_i;
                        next_r.st = C_ISSUE;
                    end
                end
            end
            C_ISSUE: begin
                if (link.req_ready) next_r.st = C_WAIT;
            end
            C_WAIT: begin
                if (link.done) next_r.st = C_IDLE;
            end
            default: next_r.st = C_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign link.req_valid = r.st == C_ISSUE;
    assign link.req = r.rq;
    assign link.mem_rvalid = mem_rvalid_i;
    assign link.mem_rdata = mem_rdata_i;
    assign cmd_ready_o = r.st == C_IDLE;
    assign illegal_o = r.illegal;
    assign done_o = link.done;
    assign wb_valid_o = link.wb_valid;
    assign wb_data_o = link.wb_data;
    assign mov_valid_o = link.mov_valid;
    assign mov_data_o = link.mov_data;
    assign mov_rt_o = r.rt;
    assign mem_req_o = link.mem_req;
    assign mem_addr_o = link.mem_addr;

endmodule : fml_core_end

// [rtl/fml_fpu_end.sv]
// Purpose: Floating-point unit end: register file, multiply-add, loads, moves
// Assumes: Core end issues only well-formed instructions
// Notes: Unfused forms take two passes through the same multiply-add
`timescale 1ns/1ps
module fml_fpu_end (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Link to the integer core
    fml_if.fpu link
);
    typedef enum {F_IDLE, F_MAC1, F_MAC2, F_LOAD} fml_fst_e;
    typedef struct packed {
        fml_fst_e st;
        fml_pkg::fml_req_s rq;
        logic [5:0] cnt;
        logic [4:0] idx;
        logic [31:0] addr;
        logic [63:0] tmp;
        logic [31:0][31:0] sreg;
        logic done;
        logic wb_valid;
        logic [31:0] wb_data;
        logic mov_valid;
        logic [31:0] mov_data;
        logic mem_req;
    } fml_fst_s;

    fml_fst_s r, next_r;
    fml_pkg::fml_req_s q;
    logic unf, step2, neg_p, neg_a;
    logic [63:0] op_n, op_m, op_d, fa, fb, fc, res, res_d, imm_x;
    logic [31:0] res_s, span, off;
    logic [5:0] words;

    // ************************************************************
    // Register file access
    // ************************************************************
    function automatic logic [63:0] rd(
        input logic [31:0][31:0] rf,
        input logic [4:0] i,
        input logic dbl
    );
        rd = dbl ? {rf[{i[3:0], 1'b1}], rf[{i[3:0], 1'b0}]} : {32'h0, rf[i]};
    endfunction : rd

    // A double overlays the two singles 2i and 2i+1
    function automatic logic [31:0][31:0] wr(
        input logic [31:0][31:0] rf,
        input logic [4:0] i,
        input logic dbl,
        input logic [63:0] v
    );
        wr = rf;
        if (dbl) begin
            wr[{i[3:0], 1'b0}] = v[31:0];
            wr[{i[3:0], 1'b1}] = v[63:32];
        end else begin
            wr[i] = v[31:0];
        end
    endfunction : wr

    // ************************************************************
    // Multiply-add operands
    // ************************************************************
    assign q = link.req;
    assign op_n = rd(r.sreg, r.rq.srcn, r.rq.dbl);
    assign op_m = rd(r.sreg, r.rq.srcm, r.rq.dbl);
    assign op_d = rd(r.sreg, r.rq.dst, r.rq.dbl);
    assign unf = (r.rq.op == fml_pkg::OP_UNFUSED_MUL_ACC)
        || (r.rq.op == fml_pkg::OP_UNFUSED_MUL_SUB);
    assign step2 = r.st == F_MAC2;
    // First pass of an unfused op rounds the bare product; second adds it, or subtracts it for the subtract form
    assign fa = step2 ? r.tmp : op_n;
    assign fb = step2 ? (r.rq.dbl ? fml_pkg::ONE_D : {32'h0, fml_pkg::ONE_S}) : op_m;
    assign fc = (unf && !step2) ? 64'h0 : op_d;
    assign neg_p = step2 ? (r.rq.op == fml_pkg::OP_UNFUSED_MUL_SUB)
        : ((r.rq.op == fml_pkg::OP_FUSED_MUL_SUB)
        || (r.rq.op == fml_pkg::OP_FUSED_NEG_MUL_ACC));
    assign neg_a = !step2 && ((r.rq.op == fml_pkg::OP_FUSED_NEG_MUL_ACC)
        || (r.rq.op == fml_pkg::OP_FUSED_NEG_MUL_SUB));
    assign res = r.rq.dbl ? res_d : {32'h0, res_s};

    fml_fma #(
        .EW(fml_pkg::EXP_S),
        .MW(fml_pkg::MAN_S)
    ) u_fma_s (
        .a_i(fa[31:0]),
        .b_i(fb[31:0]),
        .c_i(fc[31:0]),
        .neg_prod_i(neg_p),
        .neg_add_i(neg_a),
        .rmode_i(r.rq.rmode),
        .res_o(res_s)
    );

    fml_fma #(
        .EW(fml_pkg::EXP_D),
        .MW(fml_pkg::MAN_D)
    ) u_fma_d (
        .a_i(fa),
        .b_i(fb),
        .c_i(fc),
        .neg_prod_i(neg_p),
        .neg_add_i(neg_a),
        .rmode_i(r.rq.rmode),
        .res_o(res_d)
    );

    // ************************************************************
    // Load address and immediate expansion
    // ************************************************************
    assign words = q.dbl ? {q.cnt[4:0], 1'b0} : q.cnt;
    assign span = 32'(words) * fml_pkg::ADDR_STEP;
    assign off = 32'(q.imm) * fml_pkg::ADDR_STEP;
    assign imm_x = q.dbl ? {q.imm[7], ~q.imm[6], {8{q.imm[6]}}, q.imm[5:0], 48'h0}
        : {32'h0, q.imm[7], ~q.imm[6], {5{q.imm[6]}}, q.imm[5:0], 19'h0};

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.wb_valid = 1'b0;
        next_r.mov_valid = 1'b0;
        case (r.st)
            F_IDLE: begin
                if (link.req_valid) begin
                    next_r.rq = q;
                    case (q.op)
                        fml_pkg::OP_FP_MOVE_IMM: begin
                            next_r.sreg = wr(r.sreg, q.dst, q.dbl, imm_x);
                            next_r.done = 1'b1;
                        end
                        fml_pkg::OP_FP_MOVE_REG: begin
                            next_r.sreg = wr(r.sreg, q.dst, q.dbl,
                                rd(r.sreg, q.srcm, q.dbl));
                            next_r.done = 1'b1;
                        end
                        fml_pkg::OP_FP_MOVE_TO_INT: begin
                            next_r.mov_data = q.half ? r.sreg[{q.srcn[3:0], 1'b1}]
                                : r.sreg[{q.srcn[3:0], 1'b0}];
                            next_r.mov_valid = 1'b1;
                            next_r.done = 1'b1;
                        end
                        fml_pkg::OP_MULTI_REG_LOAD: begin
                            next_r.cnt = words;
                            // Decrement-before: block ends at base minus one word
                            next_r.addr = q.decb ? q.base - span : q.base;
                            next_r.wb_data = q.decb ? q.base - span : q.base + span;
                            next_r.idx = q.dbl ? {q.dst[3:0], 1'b0} : q.dst;
                            next_r.mem_req = 1'b1;
                            next_r.st = F_LOAD;
                        end
                        fml_pkg::OP_SINGLE_REG_LOAD: begin
                            next_r.cnt = q.dbl ? 6'h2 : 6'h1;
                            next_r.addr = q.sub ? q.base - off : q.base + off;
                            next_r.idx = q.dbl ? {q.dst[3:0], 1'b0} : q.dst;
                            next_r.mem_req = 1'b1;
                            next_r.st = F_LOAD;
                        end
                        default: begin
                            next_r.st = F_MAC1;
                        end
                    endcase
                end
            end
            F_MAC1, F_MAC2: begin
                if ((r.st == F_MAC1) && unf) begin
                    next_r.tmp = res;
                    next_r.st = F_MAC2;
                end else begin
                    next_r.sreg = wr(r.sreg, r.rq.dst, r.rq.dbl, res);
                    next_r.done = 1'b1;
                    next_r.st = F_IDLE;
                end
            end
            F_LOAD: begin
                if (link.mem_rvalid) begin
                    // Low word of a double sits at the lower address
                    next_r.sreg[r.idx] = link.mem_rdata;
                    next_r.idx = r.idx + 5'h1;
                    next_r.addr = r.addr + fml_pkg::ADDR_STEP;
                    next_r.cnt = r.cnt - 6'h1;
                    if (r.cnt == 6'h1) begin
                        next_r.mem_req = 1'b0;
                        next_r.done = 1'b1;
                        next_r.wb_valid = (r.rq.op == fml_pkg::OP_MULTI_REG_LOAD)
                            && r.rq.wback;
                        next_r.st = F_IDLE;
                    end
                end
            end
            default: begin
                next_r.st = F_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // The link has no flag path, so condition flags stay with the core
    assign link.done = r.done;
    assign link.req_ready = r.st == F_IDLE;
    assign link.wb_valid = r.wb_valid;
    assign link.wb_data = r.wb_data;
    assign link.mov_valid = r.mov_valid;
    assign link.mov_data = r.mov_data;
    assign link.mem_req = r.mem_req;
    assign link.mem_addr = r.addr;

endmodule : fml_fpu_end

// [test/fml_link_props.sv]
// Purpose: Link checks between the core end and the unit end
// Assumes: One clock, reset active low
// Notes: Watches the interface signals only
`timescale 1ns/1ps
module fml_link_props (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Link
    input wire logic req_valid,
    input wire logic req_ready,
    input wire fml_pkg::fml_req_s req,
    input wire logic done,
    input wire logic wb_valid,
    input wire logic [31:0] wb_data,
    input wire logic mov_valid,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic mem_rvalid
);
    logic take;
    logic ld;
    logic [31:0] span;
    logic [31:0] exp_wb;
    assign take = req_valid && req_ready;
    assign ld = take && req.op == fml_pkg::OP_MULTI_REG_LOAD;
    assign span = {24'h0, req.cnt, 2'h0} << req.dbl;
    // New base kept from the take, since the request may change before done
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            exp_wb <= 32'h0;
        end else if (take) begin
            exp_wb <= req.decb ? req.base - span : req.base + span;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    property p_ia_start; ld && !req.decb |=> mem_req && mem_addr == $past(req.base); endproperty
    a_ia_start: assert property (p_ia_start) else $error("ia start");
    property p_db_start; ld && req.decb |=> mem_req && mem_addr == exp_wb; endproperty
    a_db_start: assert property (p_db_start) else $error("db start");
    property p_step; mem_req && mem_rvalid ##1 mem_req |-> mem_addr == $past(mem_addr) + 32'h4;
    endproperty
    a_step: assert property (p_step) else $error("addr step");
    property p_hold; mem_req && !mem_rvalid |=> mem_req && $stable(mem_addr); endproperty
    a_hold: assert property (p_hold) else $error("addr hold");
    property p_fused; take && req.op < fml_pkg::OP_UNFUSED_MUL_ACC |=> !done ##1 done; endproperty
    a_fused: assert property (p_fused) else $error("fused timing");
    property p_unfused; take && (req.op == fml_pkg::OP_UNFUSED_MUL_ACC
        || req.op == fml_pkg::OP_UNFUSED_MUL_SUB) |=> !done [*2] ##1 done; endproperty
    a_unfused: assert property (p_unfused) else $error("unfused timing");
    property p_move; take && req.op >= fml_pkg::OP_FP_MOVE_IMM |=> done; endproperty
    a_move: assert property (p_move) else $error("move timing");
    property p_wb; wb_valid |-> done && wb_data == exp_wb; endproperty
    a_wb: assert property (p_wb) else $error("writeback value");
    property p_mov; mov_valid |-> done; endproperty
    a_mov: assert property (p_mov) else $error("move without done");
endmodule : fml_link_props

// [test/fpu_fused_mac_load_move_bench.sv]
// Purpose: Drives both link ends through loads, moves and multiply-adds
// Assumes: Memory answers every other cycle to exercise address hold
// Notes: Unit registers are read back through the move to integer
`timescale 1ns/1ps
module fpu_fused_mac_load_move_bench;
    logic sys_clk_i, rstn_i, cmd_valid_i, cmd_ready_o, illegal_o, done_o, wb_valid_o;
    logic mov_valid_o, mem_req_o, mem_rvalid_i, s_wb, s_ill, s_mv, cyc;
    fml_pkg::fml_req_s cmd_i, c;
    logic [1:0] cmd_size_i;
    logic [9:0] cmd_off_i;
    logic [3:0] cmd_rt_i, mov_rt_o;
    logic [31:0] wb_data_o, mov_data_o, mem_addr_o, mem_rdata_i, s_wbd, s_mov;
    int n_errors, n_tests;
    fml_if u_fml_if ();
    fml_core_end u_fml_core_end (.sys_clk_i, .rstn_i, .cmd_valid_i, .cmd_i, .cmd_size_i,
        .cmd_off_i, .cmd_rt_i, .cmd_ready_o, .illegal_o, .done_o, .wb_valid_o, .wb_data_o,
        .mov_valid_o, .mov_data_o, .mov_rt_o, .mem_req_o, .mem_addr_o, .mem_rvalid_i,
        .mem_rdata_i, .link(u_fml_if.core));
    fml_fpu_end u_fml_fpu_end (.sys_clk_i, .rstn_i, .link(u_fml_if.fpu));
    fml_link_props u_fml_link_props (.sys_clk_i, .rstn_i, .req_valid(u_fml_if.req_valid),
        .req_ready(u_fml_if.req_ready), .req(u_fml_if.req), .done(u_fml_if.done),
        .wb_valid(u_fml_if.wb_valid), .wb_data(u_fml_if.wb_data),
        .mov_valid(u_fml_if.mov_valid), .mem_req(u_fml_if.mem_req),
        .mem_addr(u_fml_if.mem_addr), .mem_rvalid(u_fml_if.mem_rvalid));
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    // Memory: 1.0, 2.0, 3.0, 0.5 at the bottom, address pattern elsewhere
    always @(posedge sys_clk_i) begin
        #1;
        cyc <= ~cyc;
        mem_rvalid_i <= mem_req_o && cyc;
        mem_rdata_i <= mem_addr_o == 32'h0 ? fml_pkg::ONE_S : mem_addr_o == 32'h4 ? 32'h4000_0000
            : mem_addr_o == 32'h8 ? 32'h4040_0000 : mem_addr_o == 32'hc ? 32'h3f00_0000
            : mem_addr_o ^ 32'h5a5a_0000;
    end
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic issue(input logic [9:0] off, input logic [3:0] rt);
        int k;
        cmd_i <= c;
        cmd_off_i <= off;
        cmd_rt_i <= rt;
        cmd_valid_i <= 1'b1;
        @(posedge sys_clk_i);
        #1;
        cmd_valid_i <= 1'b0;
        k = 0;
        while (done_o !== 1'b1 && illegal_o !== 1'b1 && k < 60) begin
            @(posedge sys_clk_i);
            #1;
            k++;
        end
        s_ill = illegal_o;
        s_wb = wb_valid_o;
        s_wbd = wb_data_o;
        s_mv = mov_valid_o;
        s_mov = mov_data_o;
        chk(k < 60, "no answer");
        @(posedge sys_clk_i);
        #1;
    endtask : issue
    task automatic rd(input logic [4:0] d, input logic h, input logic [31:0] e);
        c = '0;
        c.op = fml_pkg::OP_FP_MOVE_TO_INT;
        c.dbl = 1'b1;
        c.srcn = d;
        c.half = h;
        issue(10'h0, 4'h3);
        chk(s_mv === 1'b1 && s_mov === e && mov_rt_o === 4'h3, "moved word");
    endtask : rd
    task automatic t_load;
        c = '0;
        c.op = fml_pkg::OP_MULTI_REG_LOAD;
        c.cnt = 6'h4;
        c.wback = 1'b1;
        issue(10'h0, 4'h0);
        chk(s_wb === 1'b1 && s_wbd === 32'h10, "ia writeback");
        rd(5'h1, 1'b1, 32'h3f00_0000);
        c.op = fml_pkg::OP_MULTI_REG_LOAD;
        c.wback = 1'b1;
        c.dbl = 1'b1;
        c.dst = 5'h2;
        c.decb = 1'b1;
        c.cnt = 6'h1;
        c.base = 32'h20;
        issue(10'h0, 4'h0);
        chk(s_wb === 1'b1 && s_wbd === 32'h18, "db writeback");
        rd(5'h2, 1'b0, 32'h5a5a_0018);
        rd(5'h2, 1'b1, 32'h5a5a_001c);
        $display("test load done");
    endtask : t_load
    task automatic t_mac;
        logic [31:0] e [6];
        e = '{32'h40e0_0000, 32'hc0a0_0000, 32'hc0e0_0000, 32'h40a0_0000, 32'h40e0_0000,
            32'hc0a0_0000};
        for (int i = 0; i < 6; i++) begin
            c = '0;
            c.op = fml_pkg::OP_FP_MOVE_REG;
            c.dst = 5'h8;
            issue(10'h0, 4'h0);
            c.op = fml_pkg::fml_op_e'(i[3:0]);
            c.srcn = 5'h1;
            c.srcm = 5'h2;
            issue(10'h0, 4'h0);
            rd(5'h4, 1'b0, e[i]);
        end
        c = '0;
        c.dst = 5'h8;
        c.srcn = 5'h4;
        c.srcm = 5'h2;
        c.rmode = fml_pkg::RM_MINUS;
        issue(10'h0, 4'h0);
        rd(5'h4, 1'b0, 32'h5b23_8011);
        $display("test mac done");
    endtask : t_mac
    task automatic t_misc;
        c = '0;
        c.op = fml_pkg::OP_FP_MOVE_IMM;
        c.dbl = 1'b1;
        c.dst = 5'h5;
        c.imm = 8'h70;
        issue(10'h0, 4'h0);
        rd(5'h5, 1'b1, 32'h3ff0_0000);
        c = '0;
        c.op = fml_pkg::OP_SINGLE_REG_LOAD;
        c.dst = 5'hc;
        c.sub = 1'b1;
        c.base = 32'h400;
        issue(10'h3fc, 4'h0);
        rd(5'h6, 1'b0, 32'h4000_0000);
        $display("test misc done");
    endtask : t_misc
    task automatic t_bad;
        c = '0;
        c.op = fml_pkg::OP_MULTI_REG_LOAD;
        issue(10'h0, 4'h0);
        chk(s_ill === 1'b1, "empty list");
        c.cnt = 6'h1;
        cmd_size_i <= fml_pkg::SIZE_64;
        issue(10'h0, 4'h0);
        cmd_size_i <= fml_pkg::SIZE_NONE;
        chk(s_ill === 1'b1, "size mismatch");
        c.op = fml_pkg::OP_FP_MOVE_TO_INT;
        issue(10'h0, 4'hf);
        chk(s_ill === 1'b1, "pc target");
        $display("test refusals done");
    endtask : t_bad
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    initial begin
        rstn_i = 1'b0;
        cmd_valid_i = 1'b0;
        cmd_i = '0;
        cmd_size_i = 2'h0;
        cmd_off_i = 10'h0;
        cmd_rt_i = 4'h0;
        mem_rvalid_i = 1'b0;
        mem_rdata_i = 32'h0;
        cyc = 1'b0;
        repeat (2) @(posedge sys_clk_i);
        #1;
        rstn_i = 1'b1;
        chk(cmd_ready_o === 1'b1 && done_o === 1'b0, "reset idle");
        t_load();
        t_mac();
        t_misc();
        t_bad();
        conclude();
    end
    // Watchdog well beyond the hundred or so cycles the tests need
    initial begin
        #100000;
        n_errors++;
        conclude();
    end
endmodule : fpu_fused_mac_load_move_bench
